//--- hdbm_bus_mode.v
/*
 * bus-mode control of the dma master: wishbone register slave, memory
 * command selection, burst limit, alignment boundary and transmit
 * auto-poll timer. assumes a classic wishbone master on ref_clk_i and a
 * dma core that presents each transfer and accepts the chosen command.
 */
// How it works
// R1: with write-invalidate enabled, a write covering a full cache line gets write-and-invalidate.
// R2: with write-invalidate disabled, every write uses the ordinary memory write command.
// R3: with read-line enabled, a read reaching the line boundary gets read line, else plain read; the code picks read multiple first for full-line reads.
// R4: with read-multiple enabled, a full-line read gets read multiple, unaligned reads plain read.
// R5: in transmit-suspended state the poll timer fires every 200, 800 or 1600 us, or never for 00; the code adds the fetch latency to each period.
// R6: the alignment field gives 8, 16 or 32 doubleword bursts boundaries, 00 reserved and default.
// R7: the burst field caps doublewords per transaction at 0 (unlimited), 1, 2, 4, 8, 16 or 32.
// R8: software stops transmit and receive before it rewrites any configuration field.
// R9: each poll reads the descriptor and transmit starts only when its ownership bit is set.
// R10: reserved bits of the bus-mode register ignore writes and read as zero.
`timescale 1ns/100ps
`include "hdbm_regs.vh"

module hdbm_bus_mode #(
  parameter POLL_CYC_1 = `HDBM_POLL_CYC_1,
  parameter POLL_CYC_2 = `HDBM_POLL_CYC_2,
  parameter POLL_CYC_3 = `HDBM_POLL_CYC_3
) (
  // clock and reset
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // transfer request from the dma core
  input  wire        xfer_req_i,
  input  wire        xfer_write_i,
  input  wire        xfer_full_line_i,
  input  wire        xfer_line_bound_i,
  output reg  [3:0]  xfer_cmd_o,
  output reg         xfer_cmd_vld_o,
  // burst configuration to the dma core
  output reg  [5:0]  max_burst_length_o,
  output reg  [5:0]  align_dw_o,
  // transmit descriptor polling
  input  wire        tx_suspended_i,
  output reg         desc_fetch_o,
  input  wire        desc_done_i,
  input  wire        desc_own_i,
  output reg         tx_start_o
);

  // ************************************************************
  // registers
  // ************************************************************
  reg  [31:0] bus_mode_control_reg;
  reg  [31:0] poll_cnt_reg;
  reg         fetch_busy_reg;
  reg  [7:0]  poll_count_reg;

  // register selects of the address decoder
  localparam [1:0] SEL_NONE = 2'b00;
  localparam [1:0] SEL_MODE = 2'b01;
  localparam [1:0] SEL_STAT = 2'b10;

  // a request counts as new until it has been acknowledged
  wire        wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // configuration fields as the dma core sees them
  wire        wie    = bus_mode_control_reg[`HDBM_WIE_BIT];
  wire        rle    = bus_mode_control_reg[`HDBM_RLE_BIT];
  wire        rme    = bus_mode_control_reg[`HDBM_RME_BIT];
  wire [1:0]  poll   = bus_mode_control_reg[`HDBM_POLL_HI:`HDBM_POLL_LO];
  wire [1:0]  align  = bus_mode_control_reg[`HDBM_ALIGN_HI:`HDBM_ALIGN_LO];
  wire [5:0]  burst  = bus_mode_control_reg[`HDBM_BURST_HI:`HDBM_BURST_LO];

  // byte-lane expansion of sel
  function [31:0] lane_mask;
    input [3:0] sel;
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // ************************************************************
  // address decode, shared by the write and the read path
  // ************************************************************
  function [1:0] decode_adr;
    input [7:0] adr;
    begin
      if (adr == `HDBM_BUS_MODE_OFS) begin
        decode_adr = SEL_MODE;
      end else if (adr == `HDBM_DMA_STAT_OFS) begin
        decode_adr = SEL_STAT;
      end else begin
        decode_adr = SEL_NONE;  // everything else reads zero and ignores writes
      end
    end
  endfunction

  // poll interval in cycles, zero when polling is off
  reg [31:0] poll_limit;
  always @* begin
    case (poll)
      2'b01:   poll_limit = POLL_CYC_1;
      2'b10:   poll_limit = POLL_CYC_2;
      2'b11:   poll_limit = POLL_CYC_3;
      default: poll_limit = 32'h00000000;
    endcase
  end

  // ************************************************************
  // wishbone slave: one registered ack cycle per access, after one wait state
  // ************************************************************
  // ack follows each new request by one cycle and drops in the next
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // writes honour sel; reserved bits are masked so they stay zero
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      bus_mode_control_reg <= `HDBM_BUS_MODE_RST;
    end else if (wb_req && wb_we_i && decode_adr(wb_adr_i) == SEL_MODE) begin
      bus_mode_control_reg <= (bus_mode_control_reg & ~(lane_mask(wb_sel_i) & `HDBM_BUS_MODE_WMASK)) |
                              (wb_dat_i & lane_mask(wb_sel_i) & `HDBM_BUS_MODE_WMASK); // [R10]
    end
  end

  // read data stands only in the ack cycle, so a stale word never looks like an answer
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_req && !wb_we_i) begin
      if (decode_adr(wb_adr_i) == SEL_MODE) begin
        wb_dat_o <= bus_mode_control_reg & `HDBM_BUS_MODE_WMASK; // [R10]
      end else if (decode_adr(wb_adr_i) == SEL_STAT) begin
        wb_dat_o <= {23'h000000, fetch_busy_reg, poll_count_reg};
      end else begin
        wb_dat_o <= 32'h00000000; // unmapped reads give zero
      end
    end else begin
      wb_dat_o <= 32'h00000000;
    end
  end

  // ************************************************************
  // memory command selection and burst shaping
  // ************************************************************
  // read multiple outranks read line when a full line also reaches the boundary
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      xfer_cmd_o         <= `HDBM_CMD_MEM_READ;
      xfer_cmd_vld_o     <= 1'b0;
    end else begin
      xfer_cmd_vld_o <= xfer_req_i;
      if (xfer_write_i) begin
        if (wie && xfer_full_line_i)
          xfer_cmd_o <= `HDBM_CMD_WRITE_INV;  // [R1]
        else
          xfer_cmd_o <= `HDBM_CMD_MEM_WRITE;  // [R2]
      end else if (rme && xfer_full_line_i) begin
        xfer_cmd_o <= `HDBM_CMD_READ_MULT;    // [R4]
      end else if (rle && xfer_line_bound_i) begin
        xfer_cmd_o <= `HDBM_CMD_READ_LINE;    // [R3]
      end else begin
        xfer_cmd_o <= `HDBM_CMD_MEM_READ;     // [R3] [R4]
      end
    end
  end

  // burst limit and alignment follow the register one cycle after a write
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      max_burst_length_o <= `HDBM_BURST_RST;
      align_dw_o         <= `HDBM_ALIGN_DW_NONE;
    end else begin
      // only zero and power-of-two values are legal; others behave as unlimited
      case (burst)
        6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20: max_burst_length_o <= burst; // [R7]
        default: max_burst_length_o <= 6'h00;
      endcase
      case (align)
        2'b01:   align_dw_o <= `HDBM_ALIGN_DW_8;     // [R6]
        2'b10:   align_dw_o <= `HDBM_ALIGN_DW_16;    // [R6]
        2'b11:   align_dw_o <= `HDBM_ALIGN_DW_32;    // [R6]
        default: align_dw_o <= `HDBM_ALIGN_DW_NONE;  // reserved: no boundary
      endcase
    end
  end

  // ************************************************************
  // transmit auto-poll
  // ************************************************************
  // timer runs only while suspended and idle, so a slow fetch never stacks polls
  // limitation: the interval restarts after each fetch, so the period grows by the fetch latency
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      poll_cnt_reg   <= 32'h00000000;
      fetch_busy_reg <= 1'b0;
      desc_fetch_o   <= 1'b0;
      tx_start_o     <= 1'b0;
      poll_count_reg <= 8'h00;
    end else begin
      desc_fetch_o <= 1'b0;
      tx_start_o   <= 1'b0;
      if (fetch_busy_reg) begin
        if (desc_done_i) begin
          fetch_busy_reg <= 1'b0;
          tx_start_o     <= desc_own_i;  // [R9]
        end
      end else if (!tx_suspended_i || poll_limit == 32'h00000000) begin
        poll_cnt_reg <= 32'h00000000;    // [R5]
      end else if (poll_cnt_reg >= poll_limit - 32'h00000001) begin
        poll_cnt_reg   <= 32'h00000000;
        desc_fetch_o   <= 1'b1;          // [R5] [R9]
        fetch_busy_reg <= 1'b1;
        poll_count_reg <= poll_count_reg + 8'h01;
      end else begin
        poll_cnt_reg <= poll_cnt_reg + 32'h00000001;
      end
    end
  end

endmodule // hdbm_bus_mode

//--- hdbm_bus_mode_bench.sv
/* self-checking bench of the bus-mode block; poll counts shortened to 20/40/80 cycles */
`timescale 1ns/100ps
`include "hdbm_regs.vh"
module hdbm_bus_mode_bench;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, req = 0, wr = 0, full = 0, bnd = 0, susp = 0, own = 0;
  logic [7:0] adr = 0;
  logic [31:0] dat = 0, rd, dat_o, m, x;
  logic [3:0] cmd, sel = 4'hf;
  logic [5:0] burst, align;
  logic ack, vld, fetch, done, d_own, start;
  int fail_count, compares, cyc_n, fetches, starts, exp_starts, n;
  always #2 clk = ~clk;
  hdbm_bus_mode #(.POLL_CYC_1(20), .POLL_CYC_2(40), .POLL_CYC_3(80)) hdbm_bus_mode_i (.ref_clk_i(clk), .rst_n_i(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .xfer_req_i(req), .xfer_write_i(wr), .xfer_full_line_i(full), .xfer_line_bound_i(bnd),
    .xfer_cmd_o(cmd), .xfer_cmd_vld_o(vld), .max_burst_length_o(burst), .align_dw_o(align), .tx_suspended_i(susp),
    .desc_fetch_o(fetch), .desc_done_i(done), .desc_own_i(d_own), .tx_start_o(start));
  hdbm_host_model hdbm_host_model_i (.ref_clk_i(clk), .desc_fetch_i(fetch), .own_i(own), .desc_done_o(done),
    .desc_own_o(d_own));
  task check(input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // classic single cycle: request held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 0; stb <= 0;
  endtask
  // counts of polls and starts seen at the ports
  always @(posedge clk) begin
    cyc_n++;
    if (fetch === 1'b1) fetches++;
    if (start === 1'b1) starts++;
    if (done && d_own) exp_starts++;
    if (cyc_n == 20000) begin
      $display("unexpected at %0t: timeout", $time);
      fail_count++;
      summarize;
    end
  end
  initial begin
    void'($urandom(32'h9a09));
    repeat (12) @(posedge clk);
    rst_n <= 1;
    susp <= 1; // polling disabled after reset
    wb(0, 8'h00, 0); check(rd, 32'h00001000); check(burst, 6'h10); check(cmd, 4'h6);
    repeat (60) @(posedge clk);
    susp <= 0;
    wb(1, 8'h00, 32'hffffffff); wb(0, 8'h00, 0); check(rd, 32'h01a6ffff);
    wb(0, 8'h04, 0); check(rd, 32'h0);
    x = `HDBM_BUS_MODE_WMASK; // every writable bit is set after the all-ones write
    for (int i = 0; i < 40; i++) begin
      m = $urandom;
      if (m[0]) m[13:8] = 6'h1 << m[3:1];
      sel <= m[31:28];
      wb(1, 8'h00, m);
      sel <= 4'hf;
      wb(0, 8'h00, 0);
      for (int b = 0; b < 4; b++) if (m[28 + b]) x[8 * b +: 8] = m[8 * b +: 8];
      x &= `HDBM_BUS_MODE_WMASK;
      check(rd, x);
      check(burst, (x[13:8] inside {1, 2, 4, 8, 16, 32}) ? x[13:8] : 6'h0);
      check(align, x[15:14] ? 6'h4 << x[15:14] : 6'h0);
      @(posedge clk);
      req <= 1; wr <= m[4]; full <= m[5]; bnd <= m[6];
      @(posedge clk); req <= 0;
      @(posedge clk);
      check(vld, 1);
      check(cmd, m[4] ? (x[24] && m[5] ? 4'hf : 4'h7) : (x[21] && m[5]) ? 4'hc : (x[23] && m[6]) ? 4'he : 4'h6);
    end
    for (int t = 1; t < 4; t++) begin
      wb(1, 8'h00, t << 17);
      own <= t[0]; susp <= 1; n = 0;
      while (fetch !== 1'b1 && n < 500) begin @(posedge clk); n++; end
      check(n >= (10 << t) && n <= (10 << t) + 2, 1);
      repeat (12) @(posedge clk);
      susp <= 0;
    end
    wb(0, `HDBM_DMA_STAT_OFS, 0); check(rd, 32'h00000003);
    check(fetches, 3);
    check(starts, exp_starts); check(exp_starts, 2);
    summarize;
  end
endmodule // hdbm_bus_mode_bench

//--- hdbm_bus_mode_properties.sv
/* checker of the bus-mode block ports; bound to every instance of hdbm_bus_mode */
`timescale 1ns/100ps
`include "hdbm_regs.vh"
module hdbm_bus_mode_properties #(parameter POLL_CYC_1 = 20, POLL_CYC_2 = 40, POLL_CYC_3 = 80) (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        xfer_req_i,
  input wire logic        xfer_write_i,
  input wire logic        xfer_full_line_i,
  input wire logic        xfer_line_bound_i,
  input wire logic [3:0]  xfer_cmd_o,
  input wire logic        xfer_cmd_vld_o,
  input wire logic [5:0]  max_burst_length_o,
  input wire logic [5:0]  align_dw_o,
  input wire logic        desc_fetch_o,
  input wire logic        desc_done_i,
  input wire logic        desc_own_i,
  input wire logic        tx_start_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // shadow of the write-invalidate enable, taken on the same edge as the register write
  localparam logic [31:0] MODE_RST = `HDBM_BUS_MODE_RST;
  logic wie_s;
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wie_s <= MODE_RST[`HDBM_WIE_BIT];
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == `HDBM_BUS_MODE_OFS && wb_sel_i[3]) begin
      wie_s <= wb_dat_i[`HDBM_WIE_BIT];
    end
  end
  write_inval_a: assert property (xfer_req_i && xfer_write_i && xfer_full_line_i && wie_s |=> xfer_cmd_o == `HDBM_CMD_WRITE_INV) else $error("full-line write not invalidating");
  inval_off_a: assert property (xfer_req_i && xfer_write_i && !wie_s |=> xfer_cmd_o == `HDBM_CMD_MEM_WRITE) else $error("invalidate while disabled");
  // a descriptor came back, with or without ownership
  sequence own_done; desc_done_i && desc_own_i; endsequence
  sequence not_own_done; desc_done_i && !desc_own_i; endsequence
  plain_write_a: assert property (xfer_req_i && xfer_write_i && !xfer_full_line_i |=> xfer_cmd_vld_o && xfer_cmd_o == `HDBM_CMD_MEM_WRITE) else $error("partial write not plain");
  write_cmd_a: assert property (xfer_req_i && xfer_write_i |=> xfer_cmd_o inside {`HDBM_CMD_MEM_WRITE, `HDBM_CMD_WRITE_INV}) else $error("bad write command");
  plain_read_a: assert property (xfer_req_i && !xfer_write_i && !xfer_full_line_i && !xfer_line_bound_i |=> xfer_cmd_o == `HDBM_CMD_MEM_READ) else $error("unaligned read not plain");
  read_cmd_a: assert property (xfer_req_i && !xfer_write_i |=> xfer_cmd_o inside {4'h6, 4'hc, 4'he}) else $error("bad read command");
  burst_legal_a: assert property (max_burst_length_o inside {6'h0, 6'h1, 6'h2, 6'h4, 6'h8, 6'h10, 6'h20}) else $error("illegal burst limit");
  align_legal_a: assert property (align_dw_o inside {6'h0, 6'h8, 6'h10, 6'h20}) else $error("illegal alignment");
  fetch_pulse_a: assert property (desc_fetch_o |=> !desc_fetch_o [*2]) else $error("fetch pulse too long");
  own_start_a: assert property (own_done |=> tx_start_o) else $error("owned descriptor not started");
  no_own_start_a: assert property (not_own_done |=> !tx_start_o) else $error("start without ownership");
  reserved_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |-> (wb_dat_o & ~`HDBM_BUS_MODE_WMASK) == 32'h0) else $error("reserved bits read nonzero");
endmodule // hdbm_bus_mode_properties
bind hdbm_bus_mode hdbm_bus_mode_properties #(.POLL_CYC_1(POLL_CYC_1), .POLL_CYC_2(POLL_CYC_2), .POLL_CYC_3(POLL_CYC_3))
  hdbm_bus_mode_properties_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .xfer_req_i(xfer_req_i), .xfer_write_i(xfer_write_i), .xfer_full_line_i(xfer_full_line_i),
  .xfer_line_bound_i(xfer_line_bound_i), .xfer_cmd_o(xfer_cmd_o), .xfer_cmd_vld_o(xfer_cmd_vld_o),
  .max_burst_length_o(max_burst_length_o), .align_dw_o(align_dw_o), .desc_fetch_o(desc_fetch_o),
  .desc_done_i(desc_done_i), .desc_own_i(desc_own_i), .tx_start_o(tx_start_o));

//--- hdbm_host_model.sv
/* host memory answering descriptor fetches, quickly and slowly by turns; own_i from the bench */
`timescale 1ns/100ps
module hdbm_host_model (
  input  wire logic ref_clk_i,
  input  wire logic desc_fetch_i,
  input  wire logic own_i,
  output logic      desc_done_o = 1'b0,
  output logic      desc_own_o = 1'b0
);
  int wait_n = -1;
  bit slow;
  // the ownership line carries no value outside the done pulse, so it toggles there
  always @(posedge ref_clk_i) begin
    desc_done_o <= 1'b0;
    desc_own_o <= ~desc_own_o;
    if (desc_fetch_i) begin
      wait_n <= slow ? 5 : 1;
      slow <= ~slow;
    end else if (wait_n == 0) begin
      desc_done_o <= 1'b1;
      desc_own_o <= own_i;
      wait_n <= -1;
    end else if (wait_n > 0) wait_n <= wait_n - 1;
  end
endmodule // hdbm_host_model

//--- hdbm_regs.vh
/*
 * register offsets, field positions, reset values and timing constants
 * of the bus-mode control block. assumes a 250 MHz clock.
 */
`ifndef HDBM_REGS_VH
`define HDBM_REGS_VH
// ************************************************************
// register map
// ************************************************************
`define HDBM_BUS_MODE_OFS      8'h00
`define HDBM_DMA_REQ_OFS       8'h04
`define HDBM_DMA_STAT_OFS      8'h08
`define HDBM_BUS_MODE_RST      32'h00001000
`define HDBM_BUS_MODE_WMASK    32'h01a6ffff
// ************************************************************
// field positions
// ************************************************************
`define HDBM_WIE_BIT           24
`define HDBM_RLE_BIT           23
`define HDBM_RME_BIT           21
`define HDBM_POLL_HI           18
`define HDBM_POLL_LO           17
`define HDBM_ALIGN_HI          15
`define HDBM_ALIGN_LO          14
`define HDBM_BURST_HI          13
`define HDBM_BURST_LO          8
`define HDBM_BURST_RST         6'h10
`define HDBM_ALIGN_DW_NONE     6'h00
`define HDBM_ALIGN_DW_8        6'h08
`define HDBM_ALIGN_DW_16       6'h10
`define HDBM_ALIGN_DW_32       6'h20
// ************************************************************
// memory commands
// ************************************************************
`define HDBM_CMD_MEM_READ      4'h6
`define HDBM_CMD_MEM_WRITE     4'h7
`define HDBM_CMD_READ_MULT     4'hc
`define HDBM_CMD_READ_LINE     4'he
`define HDBM_CMD_WRITE_INV     4'hf
// ************************************************************
// timing
// ************************************************************
`define HDBM_CLK_MHZ           250
`define HDBM_POLL_US_1         200
`define HDBM_POLL_US_2         800
`define HDBM_POLL_US_3         1600
`define HDBM_POLL_CYC_1        (`HDBM_POLL_US_1 * `HDBM_CLK_MHZ)
`define HDBM_POLL_CYC_2        (`HDBM_POLL_US_2 * `HDBM_CLK_MHZ)
`define HDBM_POLL_CYC_3        (`HDBM_POLL_US_3 * `HDBM_CLK_MHZ)
`endif
